// ---- hw/cpm_pkg.sv ----
// shared constants, types and helpers for the cpu clock and power-mode block
package cpm_pkg;

	// =====================================================================
	// core clock and warm-up times
	// =====================================================================
	localparam int unsigned CORE_PERIOD_NS = 40;      // 25 MHz core clock
	localparam int unsigned CFG_TIME_NS    = 4600000; // 8 slow + 2**17 fast periods
	localparam int unsigned RST_WARM_NS    = 377000;  // 2048 fast + 5 slow clocks
	localparam int unsigned WAKE_WARM_NS   = 315000;  // 64 fast + 5 slow clocks
	// least times, so round up to whole core cycles
	localparam int unsigned CFG_CYCLES      = (CFG_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int unsigned RST_WARM_CYCLES = (RST_WARM_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int unsigned WAKE_WARM_CYCLES = (WAKE_WARM_NS + CORE_PERIOD_NS - 1)
		/ CORE_PERIOD_NS;
	localparam int unsigned TMR_W = 17;               // warm-up counter width

	// =====================================================================
	// register map: printed offsets are indices, byte address is 4 * index
	// =====================================================================
	localparam logic [7:0] IDX_POWER_MODE  = 8'h87; // power_mode_control
	localparam logic [7:0] IDX_FETCH_WAIT  = 8'h8e; // fetch_wait_control
	localparam logic [7:0] IDX_P1_WAKE     = 8'h91; // port1_wake_enable
	localparam logic [7:0] IDX_CPU_DIV     = 8'he5; // cpu_clock_divider
	localparam logic [7:0] IDX_APPLY_KEY   = 8'he6; // clock_apply_key

	// field positions
	localparam int unsigned PMC_IDLE_BIT   = 0;
	localparam int unsigned PMC_STOP_BIT   = 1;
	localparam int unsigned PMC_FLAG_BIT   = 2;
	localparam int unsigned PMC_SMOD_BIT   = 7;
	localparam int unsigned FWC_WAIT_LSB   = 4;
	localparam int unsigned FWC_WAIT_MSB   = 6;

	// reset and fixed values
	localparam logic [2:0] FWC_WAIT_RESET  = 3'h7;
	localparam logic [3:0] FWC_LOW_FIXED   = 4'h1;  // read-only low nibble
	localparam logic [2:0] DIV_RESET       = 3'h7;
	localparam logic [7:0] P1_WAKE_RESET   = 8'h00;
	localparam logic [7:0] APPLY_KEY       = 8'h69;

	// =====================================================================
	// operating states
	// =====================================================================
	typedef enum logic [2:0] {
		ST_POR       = 3'b110,
		ST_CFG       = 3'b000,
		ST_RST_WARM  = 3'b001,
		ST_RUN       = 3'b010,
		ST_IDLE      = 3'b011,
		ST_STOP      = 3'b100,
		ST_WAKE_WARM = 3'b101
	} cpm_state_type;

	// divide ratio for a divider code; reserved codes fall back to 128
	function automatic logic [7:0] div_period(input logic [2:0] code);
		unique case (code)
			3'h1:    div_period = 8'h40;
			3'h2:    div_period = 8'h20;
			3'h3:    div_period = 8'h10;
			3'h4:    div_period = 8'h08;
			3'h5:    div_period = 8'h04;
			default: div_period = 8'h80;
		endcase
	endfunction : div_period

endpackage : cpm_pkg

// ---- hw/cpm_tmr_if.sv ----
// request and answer of the warm-up interval timer
`timescale 1ns/1ns
interface cpm_tmr_if;
	import cpm_pkg::*;
	logic             start; // one-cycle load request
	logic [TMR_W-1:0] load;  // interval in core cycles
	logic             done;  // one-cycle pulse at interval end
	modport ctrl (output start, output load, input done);
	modport tmr  (input start, input load, output done);
endinterface : cpm_tmr_if

// ---- hw/cpm_interval_timer.sv ----
// down-counting interval timer for configuration and warm-up waits
`timescale 1ns/1ns
module cpm_interval_timer
	import cpm_pkg::*;
(
	input  wire logic core_clk_in,
	input  wire logic resetn_in,
	cpm_tmr_if.tmr    tmr
);

	logic [TMR_W-1:0] count_reg; // cycles left
	logic             busy_reg;  // interval running
	logic             done_reg;  // end pulse

	// =====================================================================
	// count down: done comes load + 1 cycles after the start cycle (2 for load 0)
	// =====================================================================
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			count_reg <= '0;
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
		end
		else if (tmr.start)
		begin
			// a fresh start overrides any interval in flight
			count_reg <= tmr.load;
			busy_reg  <= 1'b1;
			done_reg  <= 1'b0;
		end
		else if (busy_reg && count_reg <= TMR_W'(1))
		begin
			busy_reg  <= 1'b0;
			done_reg  <= 1'b1;
		end
		else
		begin
			count_reg <= busy_reg ? count_reg - TMR_W'(1) : count_reg;
			done_reg  <= 1'b0;
		end
	end

	assign tmr.done = done_reg;

endmodule : cpm_interval_timer

// ---- hw/cpm_clock_divider.sv ----
// cpu clock enable divider: one pulse per divide period of the core clock
`timescale 1ns/1ns
module cpm_clock_divider
	import cpm_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       resetn_in,
	input  wire logic [2:0] code_in,
	input  wire logic       restart_in,
	output logic            tick_out
);

	logic [7:0] count_reg; // position inside the period
	logic       tick_reg;  // registered enable pulse

	// =====================================================================
	// free-running count, restarted when a new ratio is applied
	// =====================================================================
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			count_reg <= '0;
			tick_reg  <= 1'b0;
		end
		else if (restart_in || count_reg >= div_period(code_in) - 8'h01)
		begin
			count_reg <= '0;
			tick_reg  <= !restart_in;
		end
		else
		begin
			count_reg <= count_reg + 8'h01;
			tick_reg  <= 1'b0;
		end
	end

	assign tick_out = tick_reg;

endmodule : cpm_clock_divider

// ---- hw/cpm_power_ctrl.sv ----
// cpu clock and power-mode controller with its register slave
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module cpm_power_ctrl
	import cpm_pkg::*;
#(
	parameter int unsigned CFG_WAIT       = CFG_CYCLES,      // shorten in simulation
	parameter int unsigned RST_WARM_WAIT  = RST_WARM_CYCLES, // shorten in simulation
	parameter int unsigned WAKE_WARM_WAIT = WAKE_WARM_CYCLES // shorten in simulation
)
(
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// avalon-mm register slave
	input  wire logic [9:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// wake sources, and the watchdog hold on the slow oscillator in stop
	input  wire logic [7:0]  port0_pins_in,
	input  wire logic [7:0]  port1_pins_in,
	input  wire logic [12:0] irq_flags_in,
	input  wire logic [12:0] irq_enables_in,
	input  wire logic        global_interrupt_enable_in,
	input  wire logic        watchdog_always_in,
	// program fetch handshake
	input  wire logic        fetch_req_in,
	output logic             fetch_ready_out,
	// clock and power gating
	output logic             cpu_tick_out,
	output logic             cpu_running_out,
	output logic             fast_osc_enable_out,
	output logic             slow_osc_enable_out,
	output logic             periph_enable_out,
	output logic             irq_active_out
);

	// =====================================================================
	// declarations
	// =====================================================================
	cpm_tmr_if tmr_bus ();                  // warm-up timer request/answer

	cpm_state_type state_reg;               // current operating state
	cpm_state_type state_next;              // next operating state

	logic       ack_reg;                    // second cycle of a bus access
	logic       bus_req;                    // read or write pending
	logic       bus_accept;                 // access completes this cycle
	logic       wr_en;                      // accepted write, low lane on
	logic [7:0] wr_byte;                    // low lane write data
	logic [7:0] bus_idx;                    // register index from address
	logic [31:0] rdata_reg;                 // read data for the answer
	logic [7:0] rd_byte;                    // selected register value

	logic       idle_bit_reg;               // power_mode_control idle
	logic       stop_bit_reg;               // power_mode_control stop
	logic       gp_flag_reg;                // general_flag_zero
	logic       smod_reg;                   // bit 7 kept for the uart
	logic [2:0] program_fetch_wait_reg;     // extra fetch cycles
	logic [7:0] port1_wake_enable_reg;      // per-pin wake enables
	logic [2:0] cpu_clock_divider_reg;      // software divider choice
	logic [2:0] div_active_reg;             // divider in force
	logic       apply_pulse;                // key write seen

	logic [7:0] p0_meta_reg;                // port-0 first sync stage
	logic [7:0] p0_sync_reg;                // port-0 second sync stage
	logic [7:0] p0_prev_reg;                // port-0 previous level
	logic [7:0] p1_meta_reg;                // port-1 first sync stage
	logic [7:0] p1_sync_reg;                // port-1 second sync stage
	logic [7:0] p1_prev_reg;                // port-1 previous level
	logic       pin_wake;                   // qualified pin level change
	logic       irq_wake;                   // enabled interrupt pending
	logic       wake_idle;                  // leave idle this cycle
	logic       wake_stop;                  // leave stop this cycle

	logic       div_tick;                   // divided enable from divider
	logic       cpu_tick_reg;               // fcpu enable while running
	logic [2:0] fetch_cnt_reg;              // wait cycles spent on a fetch

	logic       run_reg;                    // cpu executing
	logic       fast_en_reg;                // fast oscillator enable
	logic       slow_en_reg;                // slow oscillator enable
	logic       periph_reg;                 // peripheral clock enable
	logic       irq_act_reg;                // interrupt logic enable

	// =====================================================================
	// avalon slave: every access takes one wait cycle
	// =====================================================================
	assign bus_req             = avs_read_in | avs_write_in;
	assign bus_accept          = bus_req & ack_reg;
	assign avs_waitrequest_out = bus_req & !ack_reg;
	assign bus_idx             = avs_address_in[9:2];
	assign wr_en               = bus_accept & avs_write_in & avs_byteenable_in[0];
	assign wr_byte             = avs_writedata_in[7:0];

	// wait-cycle marker, dropped once the access completes
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			ack_reg <= 1'b0;
		else
			ack_reg <= bus_req & !ack_reg;
	end

	// read mux; unmapped and write-only locations read zero
	always_comb
	begin
		rd_byte = 8'h00;
		unique case (bus_idx)
			IDX_POWER_MODE:
				rd_byte = {smod_reg, 4'h0, gp_flag_reg, stop_bit_reg, idle_bit_reg};
			IDX_FETCH_WAIT:
				rd_byte = {1'b0, program_fetch_wait_reg, FWC_LOW_FIXED};
			IDX_P1_WAKE:
				rd_byte = port1_wake_enable_reg;
			IDX_CPU_DIV:
				rd_byte = {5'h00, cpu_clock_divider_reg};
			default:
				rd_byte = 8'h00;
		endcase
	end

	// read data is captured in the wait cycle so it stands when accepted
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rdata_reg <= '0;
		else if (avs_read_in && !ack_reg)
			rdata_reg <= {24'h000000, rd_byte};
	end

	assign avs_readdata_out = rdata_reg;

	// =====================================================================
	// configuration registers
	// =====================================================================
	// fetch wait field, 7 extra cycles out of reset
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			program_fetch_wait_reg <= FWC_WAIT_RESET;
		else if (wr_en && bus_idx == IDX_FETCH_WAIT)
			program_fetch_wait_reg <= wr_byte[FWC_WAIT_MSB:FWC_WAIT_LSB];
	end

	// port-1 wake enables, all blocked out of reset
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			port1_wake_enable_reg <= P1_WAKE_RESET;
		else if (wr_en && bus_idx == IDX_P1_WAKE)
			port1_wake_enable_reg <= wr_byte;
	end

	// divider choice, stored but not yet in force
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			cpu_clock_divider_reg <= DIV_RESET;
		else if (wr_en && bus_idx == IDX_CPU_DIV)
			cpu_clock_divider_reg <= wr_byte[2:0];
	end

	// only the key value moves the choice into the running divider
	assign apply_pulse = wr_en && bus_idx == IDX_APPLY_KEY && wr_byte == APPLY_KEY;

	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			div_active_reg <= DIV_RESET;
		else if (apply_pulse)
			div_active_reg <= cpu_clock_divider_reg;
		// any other key value leaves the active ratio alone
	end

	// =====================================================================
	// power_mode_control: a write that sets a bit beats a wake clear
	// =====================================================================
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			idle_bit_reg <= 1'b0;
			stop_bit_reg <= 1'b0;
			gp_flag_reg  <= 1'b0;
			smod_reg     <= 1'b0;
		end
		else if (wr_en && bus_idx == IDX_POWER_MODE)
		begin
			idle_bit_reg <= wr_byte[PMC_IDLE_BIT] | (idle_bit_reg & !wake_idle);
			stop_bit_reg <= wr_byte[PMC_STOP_BIT] | (stop_bit_reg & !wake_stop);
			gp_flag_reg  <= wr_byte[PMC_FLAG_BIT];
			smod_reg     <= wr_byte[PMC_SMOD_BIT];
		end
		else
		begin
			// leaving a low-power mode clears its bit by itself
			if (wake_idle)
				idle_bit_reg <= 1'b0;
			if (wake_stop)
				stop_bit_reg <= 1'b0;
		end
	end

	// =====================================================================
	// pin change detection: two sync stages, then edge compare
	// =====================================================================
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			p0_meta_reg <= '0;
			p0_sync_reg <= '0;
			p1_meta_reg <= '0;
			p1_sync_reg <= '0;
		end
		else
		begin
			p0_meta_reg <= port0_pins_in;
			p0_sync_reg <= p0_meta_reg;
			p1_meta_reg <= port1_pins_in;
			p1_sync_reg <= p1_meta_reg;
		end
	end

	// previous level tracks the synced pins so only changes count
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			p0_prev_reg <= '0;
			p1_prev_reg <= '0;
		end
		else
		begin
			p0_prev_reg <= p0_sync_reg;
			p1_prev_reg <= p1_sync_reg;
		end
	end

	// port 0 always wakes, port 1 only where enabled
	assign pin_wake = (|(p0_sync_reg ^ p0_prev_reg))
		| (|((p1_sync_reg ^ p1_prev_reg) & port1_wake_enable_reg));
	// interrupt wake needs its own enable and the global one
	assign irq_wake = global_interrupt_enable_in
		& (|(irq_flags_in & irq_enables_in));
	assign wake_idle = state_reg == ST_IDLE && (pin_wake || irq_wake);
	assign wake_stop = state_reg == ST_STOP && pin_wake;

	// =====================================================================
	// operating state machine
	// =====================================================================
	always_comb
	begin
		state_next    = state_reg;
		tmr_bus.start = 1'b0;
		tmr_bus.load  = '0;
		unique case (state_reg)
			ST_POR:
			begin
				// launch the configuration interval
				tmr_bus.start = 1'b1;
				tmr_bus.load  = TMR_W'(CFG_WAIT);
				state_next    = ST_CFG;
			end
			ST_CFG:
				if (tmr_bus.done)
				begin
					tmr_bus.start = 1'b1;
					tmr_bus.load  = TMR_W'(RST_WARM_WAIT);
					state_next    = ST_RST_WARM;
				end
			ST_RST_WARM:
				if (tmr_bus.done)
					state_next = ST_RUN;
			ST_RUN:
				// stop takes precedence when both bits are written
				if (stop_bit_reg)
					state_next = ST_STOP;
				else if (idle_bit_reg)
					state_next = ST_IDLE;
			ST_IDLE:
				if (wake_idle)
					state_next = ST_RUN;
			ST_STOP:
				if (wake_stop)
				begin
					tmr_bus.start = 1'b1;
					tmr_bus.load  = TMR_W'(WAKE_WARM_WAIT);
					state_next    = ST_WAKE_WARM;
				end
			ST_WAKE_WARM:
				if (tmr_bus.done)
					state_next = ST_RUN;
			default:
				state_next = ST_POR;
		endcase
	end

	// every reset restarts the full power-up sequence
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state_reg <= ST_POR;
		else
			state_reg <= state_next;
	end

	cpm_interval_timer u_timer (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.tmr         (tmr_bus)
	);

	// =====================================================================
	// cpu clock enable and program fetch wait states
	// =====================================================================
	cpm_clock_divider u_divider (
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.code_in     (div_active_reg),
		.restart_in  (apply_pulse),
		.tick_out    (div_tick)
	);

	// fcpu reaches the cpu only while it executes
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			cpu_tick_reg <= 1'b0;
		else
			cpu_tick_reg <= div_tick && state_reg == ST_RUN;
	end

	// each fetch spends the programmed number of extra cpu cycles
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			fetch_cnt_reg <= '0;
		else if (!fetch_req_in || fetch_ready_out)
			fetch_cnt_reg <= '0;
		else if (cpu_tick_reg)
			fetch_cnt_reg <= fetch_cnt_reg + 3'h1;
	end

	assign fetch_ready_out = fetch_req_in && cpu_tick_reg
		&& fetch_cnt_reg == program_fetch_wait_reg;

	// =====================================================================
	// oscillator and peripheral gating per mode
	// =====================================================================
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			run_reg     <= 1'b0;
			fast_en_reg <= 1'b1;
			slow_en_reg <= 1'b1;
			periph_reg  <= 1'b0;
			irq_act_reg <= 1'b0;
		end
		else
		begin
			run_reg     <= state_reg == ST_RUN;
			fast_en_reg <= state_reg != ST_STOP;
			slow_en_reg <= state_reg != ST_STOP || watchdog_always_in;
			periph_reg  <= state_reg == ST_RUN || state_reg == ST_IDLE;
			irq_act_reg <= state_reg == ST_RUN || state_reg == ST_IDLE;
		end
	end

	assign cpu_tick_out        = cpu_tick_reg;
	assign cpu_running_out     = run_reg;
	assign fast_osc_enable_out = fast_en_reg;
	assign slow_osc_enable_out = slow_en_reg;
	assign periph_enable_out   = periph_reg;
	assign irq_active_out      = irq_act_reg;

endmodule : cpm_power_ctrl

// ---- test/cpm_power_ctrl_monitor.sv ----
// concurrent checks on the ports of the power-mode controller
`timescale 1ns/1ns
module cpm_power_ctrl_monitor #(
	parameter int unsigned CFG_WAIT      = 20, // configuration hold-off cycles
	parameter int unsigned RST_WARM_WAIT = 10  // reset warm-up cycles
)
(
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic watchdog_always_in,
	input wire logic fetch_req_in,
	input wire logic fetch_ready_out,
	input wire logic cpu_tick_out,
	input wire logic cpu_running_out,
	input wire logic fast_osc_enable_out,
	input wire logic slow_osc_enable_out,
	input wire logic periph_enable_out,
	input wire logic irq_active_out
);
	// =====================================================================
	// helper: cycles since reset release, saturating
	// =====================================================================
	logic [17:0] up_reg; // elapsed cycles, wide enough for full hold-off
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			up_reg <= 18'h00000;
		else if (up_reg != 18'h3ffff)
			up_reg <= up_reg + 18'h00001;
	end
	// =====================================================================
	// properties
	// =====================================================================
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	// a bus request waits exactly one cycle
	sequence s_one_wait;
		avs_waitrequest_out ##1 !avs_waitrequest_out;
	endsequence
	chk_bus_one_wait: assert property ($rose(avs_read_in | avs_write_in) |-> s_one_wait)
		else $error("bus wait not one cycle");
	chk_reset_hold_off: assert property (
		cpu_running_out |-> up_reg >= CFG_WAIT + RST_WARM_WAIT)
		else $error("cpu ran before hold-off ended");
	chk_wake_warm_up: assert property (
		$rose(fast_osc_enable_out) |-> !cpu_running_out [*7])
		else $error("cpu ran before wake warm-up ended");
	chk_fetch_on_tick: assert property (
		fetch_ready_out |-> cpu_tick_out && fetch_req_in)
		else $error("fetch ready off a cpu tick");
	chk_stop_all_off: assert property (
		$fell(fast_osc_enable_out) |-> !cpu_running_out
		&& !periph_enable_out && !irq_active_out)
		else $error("stop left something running");
	chk_idle_no_tick: assert property (
		!cpu_running_out && periph_enable_out |-> !cpu_tick_out)
		else $error("cpu tick while idle");
	chk_stop_slow_osc: assert property (
		!fast_osc_enable_out |-> slow_osc_enable_out == watchdog_always_in)
		else $error("slow oscillator wrong in stop");
	chk_live_gating: assert property (
		periph_enable_out |-> fast_osc_enable_out
		&& slow_osc_enable_out && irq_active_out)
		else $error("gating wrong in run or idle");
endmodule : cpm_power_ctrl_monitor

bind cpm_power_ctrl cpm_power_ctrl_monitor #(.CFG_WAIT(CFG_WAIT), .RST_WARM_WAIT(RST_WARM_WAIT))
	mon (.core_clk_in, .resetn_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
	.watchdog_always_in, .fetch_req_in, .fetch_ready_out, .cpu_tick_out, .cpu_running_out,
	.fast_osc_enable_out, .slow_osc_enable_out, .periph_enable_out, .irq_active_out);

// ---- test/cpm_power_ctrl_bench.sv ----
// self-checking bench for the power-mode controller
`timescale 1ns/1ns
module cpm_power_ctrl_bench;
	import cpm_pkg::*;
	// =====================================================================
	// signals
	// =====================================================================
	logic        core_clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic        global_interrupt_enable_in, watchdog_always_in, fetch_req_in, fetch_ready_out;
	logic        cpu_tick_out, cpu_running_out, fast_osc_enable_out, slow_osc_enable_out;
	logic        periph_enable_out, irq_active_out;
	logic [9:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	logic [3:0]  avs_byteenable_in;
	logic [7:0]  port0_pins_in, port1_pins_in, rd_q; // pins and last read byte
	logic [12:0] irq_flags_in, irq_enables_in;
	int          errors, cmp_count, wn; // wn: cycles of the last wait
	cpm_power_ctrl #(.CFG_WAIT(20), .RST_WARM_WAIT(10), .WAKE_WARM_WAIT(8)) dut (
		.core_clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.port0_pins_in, .port1_pins_in, .irq_flags_in, .irq_enables_in,
		.global_interrupt_enable_in, .watchdog_always_in, .fetch_req_in, .fetch_ready_out,
		.cpu_tick_out, .cpu_running_out, .fast_osc_enable_out, .slow_osc_enable_out,
		.periph_enable_out, .irq_active_out);
	always #20 core_clk_in = ~core_clk_in;
	// =====================================================================
	// helpers
	// =====================================================================
	task automatic test_done;
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for a level, sampled on falling edges
	task automatic wait_sig(ref logic s, input logic v);
		wn = 0;
		while (s !== v && wn < 2000)
		begin
			@(negedge core_clk_in);
			wn++;
		end
		if (wn >= 2000)
		begin
			errors++;
			$display("ERROR %0t wait timed out", $time);
			test_done();
		end
	endtask : wait_sig
	// one avalon access held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge core_clk_in);
		avs_address_in <= {idx, 2'b00};
		avs_read_in <= !w;
		avs_write_in <= w;
		avs_writedata_in <= {24'h000000, d};
		@(negedge core_clk_in);
		wait_sig(avs_waitrequest_out, 1'b0);
		@(posedge core_clk_in);
		rd_q = avs_readdata_out[7:0];
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : bus
	task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk({24'h000000, rd_q}, {24'h000000, exp});
	endtask : rreg
	// cycles between two cpu ticks; the first tick may be a stale one
	task automatic tick_gap(input int exp);
		repeat (2)
		begin
			@(negedge core_clk_in);
			wait_sig(cpu_tick_out, 1'b1);
		end
		@(negedge core_clk_in);
		wait_sig(cpu_tick_out, 1'b1);
		chk(wn + 1, exp);
	endtask : tick_gap
	// =====================================================================
	// scenarios
	// =====================================================================
	task automatic t_regs;
		rreg(IDX_POWER_MODE, 8'h00);
		rreg(IDX_FETCH_WAIT, 8'h71);
		rreg(IDX_P1_WAKE, 8'h00);
		rreg(IDX_CPU_DIV, 8'h07);
		rreg(IDX_APPLY_KEY, 8'h00);
		rreg(8'h10, 8'h00);
	endtask : t_regs
	task automatic t_div;
		logic [2:0] c;
		tick_gap(128);
		bus(1'b1, IDX_CPU_DIV, 8'h05);
		bus(1'b1, IDX_APPLY_KEY, 8'h68);
		tick_gap(128);
		for (int i = 0; i < 7; i++)
		begin
			c = 3'((i + 6) % 7);
			bus(1'b1, IDX_CPU_DIV, {5'h00, c});
			bus(1'b1, IDX_APPLY_KEY, APPLY_KEY);
			tick_gap((c < 3'h6) ? (128 >> c) : 128);
		end
	endtask : t_div
	task automatic t_fetch;
		int n;
		int g;
		for (int w = 0; w < 8; w++)
		begin
			bus(1'b1, IDX_FETCH_WAIT, {1'b0, 3'(w), 4'h0});
			rreg(IDX_FETCH_WAIT, {1'b0, 3'(w), 4'h1});
			wait_sig(cpu_tick_out, 1'b1);
			@(posedge core_clk_in);
			fetch_req_in <= 1'b1;
			n = 0;
			g = 0;
			do
			begin
				@(negedge core_clk_in);
				g++;
				if (cpu_tick_out === 1'b1)
					n++;
			end while (fetch_ready_out !== 1'b1 && g < 100);
			chk(n, w + 1);
			@(posedge core_clk_in);
			fetch_req_in <= 1'b0;
		end
	endtask : t_fetch
	task automatic t_idle;
		bus(1'b1, IDX_POWER_MODE, 8'h01);
		wait_sig(cpu_running_out, 1'b0);
		chk(periph_enable_out, 1'b1);
		@(posedge core_clk_in);
		irq_flags_in <= 13'h0001;
		irq_enables_in <= 13'h0001;
		port1_pins_in <= 8'h01;
		repeat (10) @(negedge core_clk_in);
		chk(cpu_running_out, 1'b0);
		@(posedge core_clk_in);
		global_interrupt_enable_in <= 1'b1;
		wait_sig(cpu_running_out, 1'b1);
		rreg(IDX_POWER_MODE, 8'h00);
		irq_flags_in <= 13'h0000;
		bus(1'b1, IDX_POWER_MODE, 8'h01);
		wait_sig(cpu_running_out, 1'b0);
		@(posedge core_clk_in);
		port0_pins_in <= 8'h80;
		wait_sig(cpu_running_out, 1'b1);
	endtask : t_idle
	task automatic t_stop;
		bus(1'b1, IDX_P1_WAKE, 8'h02);
		bus(1'b1, IDX_POWER_MODE, 8'h06);
		wait_sig(fast_osc_enable_out, 1'b0);
		chk(slow_osc_enable_out, 1'b0);
		@(posedge core_clk_in);
		irq_flags_in <= 13'h0001;
		port1_pins_in <= 8'h00;
		repeat (10) @(negedge core_clk_in);
		chk(fast_osc_enable_out, 1'b0);
		@(posedge core_clk_in);
		port1_pins_in <= 8'h02;
		wait_sig(cpu_running_out, 1'b1);
		rreg(IDX_POWER_MODE, 8'h04);
		watchdog_always_in <= 1'b1;
		bus(1'b1, IDX_POWER_MODE, 8'h02);
		wait_sig(fast_osc_enable_out, 1'b0);
		chk(slow_osc_enable_out, 1'b1);
		@(posedge core_clk_in);
		port0_pins_in <= 8'h00;
		wait_sig(cpu_running_out, 1'b1);
	endtask : t_stop
	task automatic t_rerun;
		@(posedge core_clk_in);
		resetn_in <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		wait_sig(cpu_running_out, 1'b1);
		chk(wn >= 30 && wn <= 40, 1'b1);
		rreg(IDX_CPU_DIV, 8'h07);
	endtask : t_rerun
	// =====================================================================
	// main sequence
	// =====================================================================
	initial
	begin
		core_clk_in = 1'b0;
		resetn_in = 1'b0;
		{avs_read_in, avs_write_in, fetch_req_in} = 3'h0;
		{global_interrupt_enable_in, watchdog_always_in} = 2'h0;
		avs_address_in = 10'h000;
		avs_writedata_in = 32'h00000000;
		avs_byteenable_in = 4'hf;
		{port0_pins_in, port1_pins_in} = 16'h0000;
		{irq_flags_in, irq_enables_in} = 26'h0000000;
		{errors, cmp_count} = 0;
		repeat (6) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		t_regs();
		wait_sig(cpu_running_out, 1'b1);
		t_div();
		t_fetch();
		t_idle();
		t_stop();
		t_rerun();
		test_done();
	end
endmodule : cpm_power_ctrl_bench
